// ==== hdl/fpi_host.sv ====
module fpi_host import fpi_pkg::*; #(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic clk,
	input wire logic rstn,
	// user request side
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqProgram,
	input wire logic [AW-1:0] reqAddr,
	input wire logic [DW-1:0] reqData,
	input wire logic powerGood,
	input wire logic protectRelease,
	output logic reqReady,
	output logic rspValid,
	output logic rspRefused,
	output logic [DW-1:0] rspData,
	// monitor pins from the board
	input wire logic programVoltageLow,
	input wire logic supplyLow,
	// flash pins
	output logic [AW-1:0] word_address_in,
	input wire logic [DW-1:0] bidirDataIn,
	output logic [DW-1:0] bidirDataOut,
	output logic bidirDataOen,
	output logic chipSelN,
	output logic outGateN,
	output logic writeStrobeN,
	output logic writeProtectN,
	output logic devResetN
);
	fpi_state_t stateReg;
	logic [CNT_W-1:0] cntReg;
	logic [CNT_W-1:0] rstCntReg;
	logic opWriteReg;
	logic [DW-1:0] dataSync;
	logic [2:0] monSync;
	logic pvLow;
	logic vccLow;
	logic pgood;
	logic refuse;

	fpi_sync #(.WIDTH(DW)) uDataSync (
		.clk(clk),
		.rstn(rstn),
		.asyncIn(bidirDataIn),
		.syncOut(dataSync)
	);
	fpi_sync #(.WIDTH(3)) uMonSync (
		.clk(clk),
		.rstn(rstn),
		.asyncIn({programVoltageLow, supplyLow, powerGood}),
		.syncOut(monSync)
	);
	assign pvLow = monSync[2];
	assign vccLow = monSync[1];
	assign pgood = monSync[0];
	// writes at low supply, and programs at low program voltage, are refused here
	assign refuse = reqWrite && (vccLow || (reqProgram && pvLow));

	// device reset stays low until power is good for a while
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rstCntReg <= '0;
			devResetN <= 1'b0;
		end else if (!pgood) begin
			rstCntReg <= '0;
			devResetN <= 1'b0;
		end else if (rstCntReg != CNT_W'(RESET_HOLD_CYC)) begin
			rstCntReg <= rstCntReg + CNT_W'(1);
		end else begin
			devResetN <= 1'b1;
		end
	end

	// write-protect follows software wish; low keeps lock-down in force
	always_ff @(posedge clk) begin
		if (!rstn) begin
			writeProtectN <= 1'b0;
		end else begin
			writeProtectN <= protectRelease;
		end
	end

	// bus cycle sequencer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			stateReg <= FPI_RST;
			cntReg <= '0;
			opWriteReg <= 1'b0;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspRefused <= 1'b0;
			rspData <= DATA_RESET;
			word_address_in <= ADDR_RESET;
			bidirDataOut <= DATA_RESET;
			bidirDataOen <= 1'b1;
			chipSelN <= 1'b1;
			outGateN <= 1'b1;
			writeStrobeN <= 1'b1;
		end else begin
			rspValid <= 1'b0;
			rspRefused <= 1'b0;
			case (stateReg)
				FPI_RST: begin
					// no cycle starts while the device is held in reset; one under way still completes
					if (devResetN) begin
						stateReg <= FPI_IDLE;
						reqReady <= 1'b1;
					end
				end
				FPI_IDLE: begin
					if (!devResetN) begin
						stateReg <= FPI_RST;
						reqReady <= 1'b0;
					end else if (reqValid && refuse) begin
						rspValid <= 1'b1;
						rspRefused <= 1'b1;
					end else if (reqValid) begin
						reqReady <= 1'b0;
						opWriteReg <= reqWrite;
						word_address_in <= reqAddr;
						bidirDataOut <= reqData;
						chipSelN <= 1'b0;
						cntReg <= CNT_W'(SETUP_CYC);
						stateReg <= FPI_SETUP;
					end
				end
				FPI_SETUP: begin
					if (cntReg > CNT_W'(1)) begin
						cntReg <= cntReg - CNT_W'(1);
					end else begin
						cntReg <= CNT_W'(STROBE_CYC);
						stateReg <= FPI_STROBE;
						if (opWriteReg) begin
							bidirDataOen <= 1'b0;
							writeStrobeN <= 1'b0;
						end else begin
							outGateN <= 1'b0;
						end
					end
				end
				FPI_STROBE: begin
					if (cntReg > CNT_W'(1)) begin
						cntReg <= cntReg - CNT_W'(1);
					end else begin
						// write strobe rises first; address and data still held
						writeStrobeN <= 1'b1;
						outGateN <= 1'b1;
						if (!opWriteReg) begin
							rspData <= dataSync;
						end
						cntReg <= CNT_W'(HOLD_CYC);
						stateReg <= FPI_HOLD;
					end
				end
				FPI_HOLD: begin
					// hold keeps data driven past the strobe edge
					if (cntReg > CNT_W'(1)) begin
						cntReg <= cntReg - CNT_W'(1);
					end else begin
						chipSelN <= 1'b1;
						bidirDataOen <= 1'b1;
						rspValid <= 1'b1;
						reqReady <= 1'b1;
						stateReg <= FPI_IDLE;
					end
				end
				default: begin
					stateReg <= FPI_RST;
				end
			endcase
		end
	end
endmodule : fpi_host

// ==== hdl/fpi_pkg.sv ====
package fpi_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	// bus cycle phase lengths in ns, and derived cycle counts at 250 MHz
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 60;
	localparam int HOLD_NS = 20;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// reset hold after power is good, in cycles
	localparam int RESET_HOLD_CYC = 64;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
	typedef enum logic [2:0] {
		FPI_RST = 3'b000,
		FPI_IDLE = 3'b001,
		FPI_SETUP = 3'b011,
		FPI_STROBE = 3'b010,
		FPI_HOLD = 3'b110
	} fpi_state_t;
endpackage : fpi_pkg

// ==== hdl/fpi_sync.sv ====
module fpi_sync import fpi_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] s1Reg;
	logic [WIDTH-1:0] s2Reg;
	logic [WIDTH-1:0] s3Reg;
	// a change counts once second and third stage agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1Reg <= '0;
			s2Reg <= '0;
			s3Reg <= '0;
			syncOut <= '0;
		end else begin
			s1Reg <= asyncIn;
			s2Reg <= s1Reg;
			s3Reg <= s2Reg;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2Reg[i] == s3Reg[i]) begin
					syncOut[i] <= s3Reg[i];
				end
			end
		end
	end
endmodule : fpi_sync

// ==== tb/fpi_flash_model.sv ====
module fpi_flash_model import fpi_pkg::*; (
	// host pins
	input wire logic [ADDR_W-1:0] word_address_in,
	input wire logic [DATA_W-1:0] bidirDataIn,
	input wire logic chipSelN,
	input wire logic outGateN,
	input wire logic writeStrobeN,
	input wire logic devResetN,
	// data toward host
	output logic [DATA_W-1:0] devOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] last = 16'h0000;
	wire logic drive = !chipSelN && !outGateN && writeStrobeN && devResetN;
	always @(posedge writeStrobeN or posedge chipSelN) begin
		if (devResetN && !(chipSelN && writeStrobeN)) begin
			mem[word_address_in] = bidirDataIn;
		end
	end
	always @(drive or word_address_in) begin
		if (drive) begin
			last = mem.exists(word_address_in) ? mem[word_address_in] : 16'hFFFF;
		end
	end
	// no pull on the bus, so released lines must not look like data
	assign devOut = drive ? last : ~last;
endmodule : fpi_flash_model

// ==== tb/fpi_host_sva.sv ====
module fpi_host_sva import fpi_pkg::*; (
	// clock, reset, power-good, flash pins and the refusal response
	input wire logic clk,
	input wire logic rstn,
	input wire logic powerGood,
	input wire logic [ADDR_W-1:0] word_address_in,
	input wire logic [DATA_W-1:0] bidirDataOut,
	input wire logic bidirDataOen,
	input wire logic chipSelN,
	input wire logic outGateN,
	input wire logic writeStrobeN,
	input wire logic devResetN,
	input wire logic rspRefused
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_pwr; !powerGood [*6] |-> !devResetN; endproperty
	a_pwr: assert property (p_pwr) else $error("reset released without power");
	property p_lat; $rose(writeStrobeN) |-> $stable(word_address_in) && $stable(bidirDataOut) && !chipSelN; endproperty
	a_lat: assert property (p_lat) else $error("write latch values moved");
	property p_wr; !writeStrobeN |-> !chipSelN && outGateN && devResetN; endproperty
	a_wr: assert property (p_wr) else $error("bad write strobe");
	property p_adr; !chipSelN && !$past(chipSelN) |-> $stable(word_address_in); endproperty
	a_adr: assert property (p_adr) else $error("address moved");
	// host may drive the bus only inside a selected write, never against the gate
	property p_bus; !bidirDataOen |-> outGateN && !chipSelN; endproperty
	a_bus: assert property (p_bus) else $error("host drives bus while device may");
	property p_gate; !outGateN |-> bidirDataOen && writeStrobeN && !chipSelN; endproperty
	a_gate: assert property (p_gate) else $error("output gate without a clean read");
	cover property (!writeStrobeN);
	cover property (!outGateN);
	cover property (rspRefused);
endmodule : fpi_host_sva
bind fpi_host fpi_host_sva i_fpi_host_sva (.*);

// ==== tb/fpi_host_test.sv ====
module fpi_host_test import fpi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic H = 1'h1;
	localparam logic L = 1'h0;
	logic clk = L, rstn = L, reqValid = L, reqWrite = L, reqProgram = L, powerGood = L;
	logic protectRelease = L, programVoltageLow = L, supplyLow = L;
	logic [ADDR_W-1:0] reqAddr = 21'h000000, word_address_in;
	logic [DATA_W-1:0] reqData = 16'h0000, rspData, bidirDataOut, devOut;
	logic reqReady, rspValid, rspRefused, bidirDataOen, chipSelN, outGateN, writeStrobeN, writeProtectN, devResetN;
	wire logic [DATA_W-1:0] bidirDataIn = bidirDataOen ? devOut : bidirDataOut;
	int fail_count = 0, comparisons = 0;
	fpi_host i_fpi_host (.*);
	fpi_flash_model i_fpi_flash_model (.*);
	initial forever #2 clk = ~clk;
	task check(input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %0t %h %h", $time, s, e);
		end
	endtask : check
	task report_and_stop;
		if (fail_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	// 0 waits for reqReady, 1 for rspValid
	task automatic wait_hi(input int which);
		int n;
		n = 0;
		while ((which == 0 ? reqReady : rspValid) !== H) begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				fail_count++;
				report_and_stop();
			end
		end
	endtask : wait_hi
	task automatic xfer(input logic w, p, input logic [20:0] a, input logic [15:0] d, input logic er);
		wait_hi(0);
		{reqValid, reqWrite, reqProgram, reqAddr, reqData} = {H, w, p, a, d};
		@(negedge clk);
		reqValid = L;
		wait_hi(1);
		check(rspRefused, er);
		if (!w) check(rspData, d);
	endtask : xfer
	task t_power;
		repeat (3) @(negedge clk);
		rstn = H;
		repeat (9) @(negedge clk);
		check(devResetN, L);
		powerGood = H;
		wait_hi(0);
		check(writeProtectN, L);
	endtask : t_power
	task t_rw;
		xfer(H, L, 21'h1FFFFF, 16'hA5C3, L);
		xfer(L, L, 21'h1FFFFF, 16'hA5C3, L);
		xfer(L, L, 21'h0AAAAA, 16'hFFFF, L);
		xfer(H, H, 21'h0AAAAA, 16'h5A3C, L);
		xfer(L, L, 21'h0AAAAA, 16'h5A3C, L);
	endtask : t_rw
	task t_refuse;
		supplyLow = H;
		repeat (5) @(negedge clk);
		xfer(H, L, 21'h0AAAAA, 16'h1111, H);
		{supplyLow, programVoltageLow} = 2'h1;
		repeat (5) @(negedge clk);
		xfer(H, H, 21'h0AAAAA, 16'h2222, H);
		xfer(H, L, 21'h0AAAAA, 16'h3333, L);
		xfer(L, L, 21'h0AAAAA, 16'h3333, L);
		programVoltageLow = L;
	endtask : t_refuse
	task t_protect;
		protectRelease = H;
		repeat (2) @(negedge clk);
		check(writeProtectN, H);
		protectRelease = L;
	endtask : t_protect
	task t_drop;
		powerGood = L;
		repeat (8) @(negedge clk);
		check({devResetN, reqReady}, 2'h0);
	endtask : t_drop
	initial begin
		t_power();
		t_rw();
		t_refuse();
		t_protect();
		t_drop();
		report_and_stop();
	end
endmodule : fpi_host_test
